// ==== rtl/icu_bank_pkg.sv ====
// Constants, field layouts and carrier types for the interrupt mask/status bank.
// Assumes a single 100 MHz APB clock domain and same-clock peripheral flags.
package icu_bank_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [31:0] IDX_KEY_MASK   = 32'h0b00_0092; // Keyboard mask
	localparam logic [31:0] IDX_GPIO_LO_M  = 32'h0b00_0094; // GPIO 0..15 mask
	localparam logic [31:0] IDX_DBG_MASK   = 32'h0b00_0096; // Debug serial mask
	localparam logic [31:0] IDX_LB_ROUTE   = 32'h0b00_0098; // Low-battery routing
	localparam logic [31:0] IDX_SW_REQ     = 32'h0b00_009a; // Software requests
	localparam logic [31:0] IDX_SYS_ST2    = 32'h0b00_0200; // System status two
	localparam logic [31:0] IDX_GPIO_HI_S  = 32'h0b00_0202; // GPIO 16..31 status
	localparam logic [31:0] IDX_IR_STAT    = 32'h0b00_0204; // Infrared status
	localparam logic [31:0] IDX_SYS_MASK2  = 32'h0b00_0206; // System mask two
	localparam logic [31:0] IDX_GPIO_HI_M  = 32'h0b00_0208; // GPIO 16..31 mask
	localparam logic [31:0] IDX_IR_MASK    = 32'h0b00_020a; // Infrared mask
	localparam logic [31:0] IDX_CTRL       = 32'h0b00_0300; // Gating control
	localparam logic [31:0] IDX_EVT_STAT   = 32'h0b00_0302; // Sticky event status
	localparam logic [31:0] IDX_EVT_MASK   = 32'h0b00_0304; // Event mask

	// ************************************************************
	// Writable bit layouts and reset value
	// ************************************************************
	localparam logic [15:0] RST_VAL    = 16'h0000; // Every register clears to zero
	localparam logic [15:0] KEY_BITS   = 16'h0007; // Bits 2..0
	localparam logic [15:0] GPIO_BITS  = 16'hffff; // All sixteen
	localparam logic [15:0] DBG_BITS   = 16'h0f00; // Bits 11..8
	localparam logic [15:0] ROUTE_BITS = 16'h0001; // Bit 0
	localparam logic [15:0] SW_BITS    = 16'h000f; // Bits 3..0
	localparam logic [15:0] SYS2_BITS  = 16'h003f; // Bits 5..0
	localparam logic [15:0] IR_BITS    = 16'h001f; // Bits 4..0
	localparam logic [15:0] CTRL_BITS  = 16'h0801; // Bit 11 and bit 0
	localparam logic [15:0] EVT_BITS   = 16'h0003; // Bits 1..0
	localparam int          CTRL_SW_EN = 11;       // Software request enable
	localparam int          CTRL_PG1EN = 0;        // Page-one DMA stop enable
	localparam int          EVT_LOWBAT = 0;        // Low-battery edge event
	localparam int          EVT_DMASTP = 1;        // DMA stop edge event

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic [2:0]  key;     // key_data_lost, key_scan_done, key_input_detect
		logic [15:0] gpio_lo; // gpio_pin_irq 0..15
		logic [15:0] gpio_hi; // gpio_pin_irq 16..31
		logic [3:0]  dbg;     // cts change, rx error, rx done, tx done
		logic [4:0]  ir;      // ir_unit_irq, ir_dma_page_irq 4..1
		logic [3:0]  sys;     // tclock, hsp, led, rtc long two
		logic        lowbat;  // Low-battery detection level
	} periph_flags_t;

	// Byte address of a register index
	function automatic logic [31:0] byte_addr(input logic [31:0] idx);
		byte_addr = {idx[29:0], 2'b00};
	endfunction

endpackage

// ==== rtl/icu_mask_status_bank.sv ====
// Second-level interrupt mask/status bank with APB register access.
// Assumes peripheral flags are levels on pclk; core lines sampled on pclk.
//
// How it works
// - Keyboard mask enables bits two to zero
// - Sixteen enable bits for GPIO pins 0-15
// - Debug serial enables sit at bits 11-8
// - Route bit: one gives line zero, else NMI
// - Four software request bits drive line zero
// - Status two shows six sources, read-only
// - Mask two enables the same six sources
// - GPIO 16-31 flags are read-only status
// - Sixteen enable bits for GPIO pins 16-31
// - Infrared status holds five read-only flags
// - Any page-two flag stops infrared DMA
// - Page-one flag stops DMA only when enabled
// - Infrared mask enables bits four to zero
// - Masks reset to zero, meaning blocked
// - Reserved bits read zero, writes ignored
// - All registers clear to zero on reset
// - Software request also needs enable bit 11
`timescale 1ns/10ps
module icu_mask_status_bank (
	input  wire  logic                        pclk,
	input  wire  logic                        presetn,
	input  wire  logic                        psel,
	input  wire  logic                        penable,
	input  wire  logic                        pwrite,
	input  wire  logic [31:0]                 paddr,
	input  wire  logic [31:0]                 pwdata,
	output logic       [31:0]                 prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire  icu_bank_pkg::periph_flags_t periph,
	output logic                              cpu_irq_line_zero,
	output logic                              lowbat_nmi,
	output logic                              ir_dma_stop,
	output logic                              irq
);
	import icu_bank_pkg::*;

	// ************************************************************
	// Storage
	// ************************************************************
	logic [15:0] key_mask;      // Keyboard enables
	logic [15:0] gpio_lo_mask;  // GPIO low enables
	logic [15:0] dbg_mask;      // Debug serial enables
	logic [15:0] lb_route;      // Holds lowbat_route_sel
	logic [15:0] sw_req;        // Holds sw_irq_request
	logic [15:0] sys_mask2;     // System mask two
	logic [15:0] gpio_hi_mask;  // GPIO high enables
	logic [15:0] ir_mask;       // Infrared enables
	logic [15:0] ctrl;          // Gating control
	logic [15:0] evt_stat;      // Sticky events
	logic [15:0] evt_mask;      // Event enables
	periph_flags_t flags;       // Sampled peripheral flags
	logic        lowbat_prev;   // Edge detector history

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire setup_ph = psel & ~penable;           // First cycle of a transfer
	wire access   = psel & penable & pready;   // Completing edge
	wire wr_acc   = access & pwrite;           // Write takes effect
	wire rd_acc   = access & ~pwrite;          // Read completes

	wire hit_key  = (paddr == byte_addr(IDX_KEY_MASK));
	wire hit_glm  = (paddr == byte_addr(IDX_GPIO_LO_M));
	wire hit_dbg  = (paddr == byte_addr(IDX_DBG_MASK));
	wire hit_rte  = (paddr == byte_addr(IDX_LB_ROUTE));
	wire hit_sw   = (paddr == byte_addr(IDX_SW_REQ));
	wire hit_st2  = (paddr == byte_addr(IDX_SYS_ST2));
	wire hit_ghs  = (paddr == byte_addr(IDX_GPIO_HI_S));
	wire hit_irs  = (paddr == byte_addr(IDX_IR_STAT));
	wire hit_m2   = (paddr == byte_addr(IDX_SYS_MASK2));
	wire hit_ghm  = (paddr == byte_addr(IDX_GPIO_HI_M));
	wire hit_irm  = (paddr == byte_addr(IDX_IR_MASK));
	wire hit_ctl  = (paddr == byte_addr(IDX_CTRL));
	wire hit_evs  = (paddr == byte_addr(IDX_EVT_STAT));
	wire hit_evm  = (paddr == byte_addr(IDX_EVT_MASK));
	wire mapped   = hit_key | hit_glm | hit_dbg | hit_rte | hit_sw | hit_st2
		| hit_ghs | hit_irs | hit_m2 | hit_ghm | hit_irm | hit_ctl
		| hit_evs | hit_evm;

	// ************************************************************
	// Status views and summaries
	// ************************************************************
	// Masked summaries per source group
	wire key_sum  = |(flags.key & key_mask[2:0]);
	wire gpio_sum = |(flags.gpio_lo & gpio_lo_mask)
		| |(flags.gpio_hi & gpio_hi_mask);
	wire dbg_sum  = |(flags.dbg & dbg_mask[11:8]);
	wire ir_sum   = |(flags.ir & ir_mask[4:0]);

	// Status registers mirror sources only; no write path exists
	wire [15:0] st2_view  = {10'h000, dbg_sum, ir_sum, flags.sys};
	wire [15:0] ghs_view  = flags.gpio_hi;
	wire [15:0] irs_view  = {11'h000, flags.ir};
	wire        st2_sum   = |(st2_view[5:0] & sys_mask2[5:0]);
	wire        sw_sum    = |sw_req[3:0] & ctrl[CTRL_SW_EN];
	wire        lb_cpu_irq_line_zero   = flags.lowbat & lb_route[0];

	// Page-two flags always stop; page-one only with its enable
	wire stop_pg2 = irs_view[3] | irs_view[2];
	wire stop_pg1 = (irs_view[1] | irs_view[0]) & ctrl[CTRL_PG1EN];

	wire next_line0 = st2_sum | key_sum | gpio_sum | sw_sum | lb_cpu_irq_line_zero;
	wire next_nmi   = flags.lowbat & ~lb_route[0];
	wire next_stop  = stop_pg2 | stop_pg1;

	// Event sources: rising low battery, rising DMA stop
	wire [15:0] evt_set = {14'h0000, next_stop & ~ir_dma_stop,
		flags.lowbat & ~lowbat_prev};
	// Clear only bits the read actually returned, so a new event survives
	wire [15:0] evt_clr = (rd_acc & hit_evs) ? prdata[15:0] : 16'h0000;
	wire [15:0] next_evt = ((evt_stat & ~evt_clr) | evt_set) & EVT_BITS;

	// ************************************************************
	// Read multiplexer, reserved bits read as zero
	// ************************************************************
	wire [15:0] rd_mux =
		  ({16{hit_key}} & key_mask)
		| ({16{hit_glm}} & gpio_lo_mask)
		| ({16{hit_dbg}} & dbg_mask)
		| ({16{hit_rte}} & lb_route)
		| ({16{hit_sw}}  & sw_req)
		| ({16{hit_st2}} & st2_view)
		| ({16{hit_ghs}} & ghs_view)
		| ({16{hit_irs}} & irs_view)
		| ({16{hit_m2}}  & sys_mask2)
		| ({16{hit_ghm}} & gpio_hi_mask)
		| ({16{hit_irm}} & ir_mask)
		| ({16{hit_ctl}} & ctrl)
		| ({16{hit_evs}} & evt_stat)
		| ({16{hit_evm}} & evt_mask);

	// Masked write value for one register
	function automatic logic [15:0] wval(input logic [31:0] d, input logic [15:0] bits);
		wval = d[15:0] & bits;
	endfunction

	// ************************************************************
	// APB answer: one wait-free access after each setup
	// ************************************************************
	// Read data latched in setup so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			if (setup_ph) begin
				prdata <= {16'h0000, rd_mux};
			end
		end
	end

	// ************************************************************
	// Mask and control registers
	// ************************************************************
	// Writes land only on the completing access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_mask     <= RST_VAL;
			gpio_lo_mask <= RST_VAL;
			dbg_mask     <= RST_VAL;
			lb_route     <= RST_VAL;
			sw_req       <= RST_VAL;
			sys_mask2    <= RST_VAL;
			gpio_hi_mask <= RST_VAL;
			ir_mask      <= RST_VAL;
			ctrl         <= RST_VAL;
			evt_mask     <= RST_VAL;
		end else if (wr_acc) begin
			if (hit_key) begin
				key_mask <= wval(pwdata, KEY_BITS);
			end
			if (hit_glm) begin
				gpio_lo_mask <= wval(pwdata, GPIO_BITS);
			end
			if (hit_dbg) begin
				dbg_mask <= wval(pwdata, DBG_BITS);
			end
			if (hit_rte) begin
				lb_route <= wval(pwdata, ROUTE_BITS);
			end
			if (hit_sw) begin
				sw_req <= wval(pwdata, SW_BITS);
			end
			if (hit_m2) begin
				sys_mask2 <= wval(pwdata, SYS2_BITS);
			end
			if (hit_ghm) begin
				gpio_hi_mask <= wval(pwdata, GPIO_BITS);
			end
			if (hit_irm) begin
				ir_mask <= wval(pwdata, IR_BITS);
			end
			if (hit_ctl) begin
				ctrl <= wval(pwdata, CTRL_BITS);
			end
			if (hit_evm) begin
				evt_mask <= wval(pwdata, EVT_BITS);
			end
		end
	end

	// ************************************************************
	// Source sampling and sticky events
	// ************************************************************
	// Flags come from same-clock logic; one register stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags       <= '0;
			lowbat_prev <= 1'b0;
			evt_stat    <= RST_VAL;
		end else begin
			flags       <= periph;
			lowbat_prev <= flags.lowbat;
			evt_stat    <= next_evt;  // Set wins over read-clear
		end
	end

	// ************************************************************
	// Core-facing outputs, all from flops
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_irq_line_zero <= 1'b0;
			lowbat_nmi        <= 1'b0;
			ir_dma_stop       <= 1'b0;
			irq               <= 1'b0;
		end else begin
			cpu_irq_line_zero <= next_line0;
			lowbat_nmi        <= next_nmi;
			ir_dma_stop       <= next_stop;
			irq               <= |(next_evt & evt_mask);
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_key_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_key) |=> (key_mask == ($past(pwdata[15:0]) & KEY_BITS)
			&& $stable(gpio_lo_mask));
	endproperty
	a_key_write: assert property (p_key_write) else $error("keyboard mask write wrong");

	property p_gpio_lo_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_glm) |=> (gpio_lo_mask == $past(pwdata[15:0]));
	endproperty
	a_gpio_lo_write: assert property (p_gpio_lo_write) else $error("gpio low mask wrong");

	property p_dbg_reserved;
		@(posedge pclk) disable iff (!presetn)
		(dbg_mask[15:12] == 4'h0) && (dbg_mask[7:0] == 8'h00);
	endproperty
	a_dbg_reserved: assert property (p_dbg_reserved) else $error("dbg reserved bit set");

	property p_nmi_route;
		@(posedge pclk) disable iff (!presetn)
		(flags.lowbat && !lb_route[0]) |=> (lowbat_nmi && !$past(lb_cpu_irq_line_zero));
	endproperty
	a_nmi_route: assert property (p_nmi_route) else $error("low battery not NMI");

	property p_sw_line;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_sw && pwdata[0] && ctrl[CTRL_SW_EN]) ##1 ctrl[CTRL_SW_EN]
			|=> cpu_irq_line_zero;
	endproperty
	a_sw_line: assert property (p_sw_line) else $error("software request lost");

	property p_sw_gate;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl[CTRL_SW_EN] && !st2_sum && !key_sum && !gpio_sum && !lb_cpu_irq_line_zero)
			|=> !cpu_irq_line_zero;
	endproperty
	a_sw_gate: assert property (p_sw_gate) else $error("line zero ungated");

	property p_status_follow;
		@(posedge pclk) disable iff (!presetn)
		##1 (st2_view[3:0] == $past(periph.sys)) && (ghs_view == $past(periph.gpio_hi));
	endproperty
	a_status_follow: assert property (p_status_follow) else $error("status not source");

	property p_pg2_stop;
		@(posedge pclk) disable iff (!presetn)
		(irs_view[3] || irs_view[2]) |=> ir_dma_stop;
	endproperty
	a_pg2_stop: assert property (p_pg2_stop) else $error("page two no stop");

	property p_pg1_gate;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl[CTRL_PG1EN] && !irs_view[3] && !irs_view[2]) |=> !ir_dma_stop;
	endproperty
	a_pg1_gate: assert property (p_pg1_gate) else $error("page one stop unguarded");

	property p_ir_mask_w;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_irm) |=> (ir_mask[15:5] == 11'h000);
	endproperty
	a_ir_mask_w: assert property (p_ir_mask_w) else $error("ir mask reserved set");

	// Debug, route, software, mask two and GPIO high writes keep only their documented bits
	property p_dbg_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_dbg) |=> (dbg_mask == ($past(pwdata[15:0]) & DBG_BITS));
	endproperty
	a_dbg_write: assert property (p_dbg_write) else $error("dbg mask write wrong");

	property p_route_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_rte) |=> (lb_route == ($past(pwdata[15:0]) & ROUTE_BITS));
	endproperty
	a_route_write: assert property (p_route_write) else $error("route write wrong");

	property p_sw_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_sw) |=> (sw_req == ($past(pwdata[15:0]) & SW_BITS));
	endproperty
	a_sw_write: assert property (p_sw_write) else $error("sw request write wrong");

	property p_mask2_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_m2) |=> (sys_mask2 == ($past(pwdata[15:0]) & SYS2_BITS));
	endproperty
	a_mask2_write: assert property (p_mask2_write) else $error("mask two write wrong");

	property p_ghm_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_ghm) |=> (gpio_hi_mask == $past(pwdata[15:0]));
	endproperty
	a_ghm_write: assert property (p_ghm_write) else $error("gpio high mask wrong");

	// Core lines follow an enabled source one edge later
	property p_lowbat_line;
		@(posedge pclk) disable iff (!presetn)
		(flags.lowbat && lb_route[0]) |=> (cpu_irq_line_zero && !lowbat_nmi);
	endproperty
	a_lowbat_line: assert property (p_lowbat_line) else $error("low battery not on line");

	property p_key_line;
		@(posedge pclk) disable iff (!presetn)
		(flags.key[2] && key_mask[2]) |=> cpu_irq_line_zero;
	endproperty
	a_key_line: assert property (p_key_line) else $error("keyboard source lost");

	property p_pg1_stop;
		@(posedge pclk) disable iff (!presetn)
		((irs_view[1] || irs_view[0]) && ctrl[CTRL_PG1EN]) |=> ir_dma_stop;
	endproperty
	a_pg1_stop: assert property (p_pg1_stop) else $error("page one no stop");

	// Status reads return the levels sampled at the setup edge
	property p_ghs_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_ghs) |-> (prdata[15:0] == $past(flags.gpio_hi));
	endproperty
	a_ghs_read: assert property (p_ghs_read) else $error("gpio status read wrong");

	property p_irs_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_irs) |-> (prdata[15:0] == {11'h000, $past(flags.ir)});
	endproperty
	a_irs_read: assert property (p_irs_read) else $error("ir status read wrong");

endmodule

// ==== verif/periph_model.sv ====
// Behavioural model of the peripheral units feeding raw flag levels into the bank.
// Assumes the bank's pclk and its asynchronous active-low reset.
`timescale 1ns/10ps
module periph_model (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire icu_bank_pkg::periph_flags_t   next_flags,
	output icu_bank_pkg::periph_flags_t        flags
);
	import icu_bank_pkg::*;

	// ************************************************************
	// Flag register
	// ************************************************************
	// Levels move only just after an edge, as a real peripheral's flops would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0; // Peripherals leave reset idle
		end else begin
			flags <= next_flags; // Whatever the bench asks for, one cycle later
		end
	end
endmodule

// ==== verif/icu_mask_status_bank_tb.sv ====
// Self-checking bench for the interrupt mask/status bank, driven over APB.
// Assumes the bank package and the peripheral model are compiled before it.
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
	$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module icu_mask_status_bank_tb;
	import icu_bank_pkg::*;

	// ************************************************************
	// Signals and tables
	// ************************************************************
	logic          pclk, presetn, psel, penable, pwrite;  // APB control
	logic [31:0]   paddr, pwdata, prdata;                 // APB data
	logic          pready, pslverr;                       // APB answer
	logic          cpu_irq_line_zero, lowbat_nmi;         // Core lines
	logic          ir_dma_stop, irq;                      // DMA stop, event irq
	periph_flags_t flag_req, periph_lvl, f;               // Requested and seen flags
	int            mismatches, tests_run, i;              // Counters
	logic [31:0]   rd;                                    // Last read data
	logic          err;                                   // Last error answer
	// First ten are writable, last four are status
	localparam logic [31:0] ALL_IDX [14] = '{IDX_KEY_MASK, IDX_GPIO_LO_M, IDX_DBG_MASK,
		IDX_LB_ROUTE, IDX_SW_REQ, IDX_SYS_MASK2, IDX_GPIO_HI_M, IDX_IR_MASK, IDX_CTRL,
		IDX_EVT_MASK, IDX_SYS_ST2, IDX_GPIO_HI_S, IDX_IR_STAT, IDX_EVT_STAT};
	localparam logic [15:0] MASK_BITS [10] = '{KEY_BITS, GPIO_BITS, DBG_BITS, ROUTE_BITS,
		SW_BITS, SYS2_BITS, GPIO_BITS, IR_BITS, CTRL_BITS, EVT_BITS};
	// Infrared flag, page-one enable and expected DMA stop
	localparam logic [4:0]  DMA_IR [7]  = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h02, 5'h01, 5'h10};
	localparam logic        DMA_EN [7]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	localparam logic        DMA_EXP [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	// Mask register, value letting one source through, value blocking only it
	localparam logic [31:0] SRC_IDX [3] = '{IDX_KEY_MASK, IDX_GPIO_LO_M, IDX_SYS_MASK2};
	localparam logic [31:0] SRC_ON [3]  = '{32'h0000_0004, 32'h0000_8000, 32'h0000_0002};
	localparam logic [31:0] SRC_OFF [3] = '{32'h0000_0003, 32'h0000_7fff, 32'h0000_003d};

	periph_model model (.pclk(pclk), .presetn(presetn), .next_flags(flag_req),
		.flags(periph_lvl));
	icu_mask_status_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .periph(periph_lvl),
		.cpu_irq_line_zero(cpu_irq_line_zero), .lowbat_nmi(lowbat_nmi),
		.ir_dma_stop(ir_dma_stop), .irq(irq));

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	// Verdict, printed in one place only
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= idx << 2; // Byte address is four times the index
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// A slave that never answers ends the run
		if (pready !== 1'b1) begin
			`CHK(pready, 1'b1)
			wrap_up();
		end
	endtask

	// Read and compare
	task automatic rchk(input logic [31:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		`CHK(rd, exp)
	endtask

	// Flag to output takes three edges here, four leaves margin
	task automatic settle();
		repeat (4) @(posedge pclk);
	endtask

	task automatic set_flags(input periph_flags_t v);
		@(posedge pclk);
		flag_req <= v;
		settle();
	endtask

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		flag_req = '0;
		mismatches = 0;
		tests_run = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Everything reads zero after reset
		for (i = 0; i < 14; i++) rchk(ALL_IDX[i], 32'h0000_0000);
		`CHK({cpu_irq_line_zero, lowbat_nmi, ir_dma_stop, irq}, 4'b0000)
		$display("test reset done");
		// All ones: only documented bits stick, reserved read zero
		for (i = 0; i < 10; i++) begin
			apb(1'b1, ALL_IDX[i], 32'hffff_ffff);
			rchk(ALL_IDX[i], {16'h0000, MASK_BITS[i]});
		end
		// Unmapped word is refused
		apb(1'b0, 32'h0b00_0400, 32'h0000_0000);
		`CHK(err, 1'b1)
		// Mid-run reset clears every mask again
		do_reset();
		for (i = 0; i < 10; i++) rchk(ALL_IDX[i], 32'h0000_0000);
		$display("test masks done");
		// Status mirrors sources; writes bounce off
		f = '0;
		f.gpio_hi = 16'ha5c3;
		f.ir = 5'h10;
		f.sys = 4'h9;
		set_flags(f);
		for (i = 10; i < 13; i++) apb(1'b1, ALL_IDX[i], 32'hffff_ffff);
		rchk(IDX_GPIO_HI_S, 32'h0000_a5c3);
		rchk(IDX_IR_STAT, 32'h0000_0010);
		rchk(IDX_SYS_ST2, 32'h0000_0009);
		`CHK(cpu_irq_line_zero, 1'b0)
		apb(1'b1, IDX_GPIO_HI_M, 32'h0000_0001);
		settle();
		`CHK(cpu_irq_line_zero, 1'b1)
		apb(1'b1, IDX_GPIO_HI_M, 32'h0000_0000);
		settle();
		`CHK(cpu_irq_line_zero, 1'b0)
		apb(1'b1, IDX_IR_MASK, 32'h0000_0010);
		settle();
		rchk(IDX_SYS_ST2, 32'h0000_0019);
		apb(1'b1, IDX_IR_MASK, 32'h0000_0000);
		$display("test status done");
		// Software request needs its enable as well
		set_flags('0);
		apb(1'b1, IDX_SW_REQ, 32'h0000_0008);
		settle();
		`CHK(cpu_irq_line_zero, 1'b0)
		apb(1'b1, IDX_CTRL, 32'h0000_0800);
		settle();
		`CHK(cpu_irq_line_zero, 1'b1)
		apb(1'b1, IDX_SW_REQ, 32'h0000_0001);
		settle();
		`CHK(cpu_irq_line_zero, 1'b1)
		apb(1'b1, IDX_SW_REQ, 32'h0000_0000);
		settle();
		`CHK(cpu_irq_line_zero, 1'b0)
		apb(1'b1, IDX_CTRL, 32'h0000_0000);
		$display("test software done");
		// Keyboard, GPIO low and mask two each let only their own source through
		f = '0;
		f.key = 3'b100;
		f.gpio_lo = 16'h8000;
		f.dbg = 4'b0100;
		f.sys = 4'h2;
		set_flags(f);
		`CHK(cpu_irq_line_zero, 1'b0)
		for (i = 0; i < 3; i++) begin
			apb(1'b1, SRC_IDX[i], SRC_ON[i]);
			settle();
			`CHK(cpu_irq_line_zero, 1'b1)
			apb(1'b1, SRC_IDX[i], SRC_OFF[i]);
			settle();
			`CHK(cpu_irq_line_zero, 1'b0)
		end
		// Debug serial summary shows in status two, then reaches line zero
		apb(1'b1, IDX_DBG_MASK, 32'h0000_0400);
		settle();
		rchk(IDX_SYS_ST2, 32'h0000_0022);
		`CHK(cpu_irq_line_zero, 1'b1)
		apb(1'b1, IDX_DBG_MASK, 32'h0000_0b00);
		settle();
		rchk(IDX_SYS_ST2, 32'h0000_0002);
		`CHK(cpu_irq_line_zero, 1'b0)
		$display("test source masks done");
		// Low battery: NMI by default, line zero once routed; sticky event
		f = '0;
		f.lowbat = 1'b1;
		set_flags(f);
		`CHK({lowbat_nmi, cpu_irq_line_zero, irq}, 3'b100)
		apb(1'b1, IDX_LB_ROUTE, 32'h0000_0001);
		settle();
		`CHK({lowbat_nmi, cpu_irq_line_zero, irq}, 3'b010)
		apb(1'b1, IDX_EVT_MASK, 32'h0000_0001);
		settle();
		`CHK(irq, 1'b1)
		rchk(IDX_EVT_STAT, 32'h0000_0001);
		settle();
		`CHK(irq, 1'b0)
		rchk(IDX_EVT_STAT, 32'h0000_0000);
		apb(1'b1, IDX_LB_ROUTE, 32'h0000_0000);
		$display("test lowbat done");
		// Infrared DMA stop for each page flag, page-one flags with and without their enable
		for (i = 0; i < 7; i++) begin
			apb(1'b1, IDX_CTRL, {31'h0000_0000, DMA_EN[i]});
			f = '0;
			f.ir = DMA_IR[i];
			set_flags(f);
			`CHK(ir_dma_stop, DMA_EXP[i])
		end
		// Rising DMA stop left its sticky event behind
		apb(1'b1, IDX_EVT_MASK, 32'h0000_0003);
		settle();
		`CHK(irq, 1'b1)
		rchk(IDX_EVT_STAT, 32'h0000_0002);
		settle();
		`CHK(irq, 1'b0)
		$display("test dma done");
		wrap_up();
	end
endmodule
